// >>> logic/pcs_serial_port.sv
// codec serial port: bit clock, frame pulse, two companded channels
`timescale 1ns/10ps
module pcs_serial_port
   import pcs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        companding_law_select,
   input  wire pcs_io_req_t io_req,
   output logic [15:0]      io_rd_data,
   output logic [1:0]       rx_sample_ready,
   output logic [1:0]       tx_space,
   output logic             serial_clk,
   output logic             frame_pulse_out,
   output logic             serial_tx_line_ch0,
   input  wire logic        serial_rx_line_ch0,
   output logic             serial_tx_line_ch1,
   input  wire logic        serial_rx_line_ch1
);

   // all state of the port outside the transmit fifos in one record
   typedef struct packed {
      logic [3:0]                   div_cnt;
      logic                         sclk;
      logic [7:0]                   bit_cnt;
      logic                         frame;
      logic [N_CH-1:0]              tx_line;
      logic [N_CH-1:0][7:0]         tx_shift;
      logic [N_CH-1:0]              rx_meta;
      logic [N_CH-1:0]              rx_sync;
      logic [N_CH-1:0][7:0]         rx_shift;
      logic [N_CH-1:0][WORD_W-1:0]  rx_word;
      logic [N_CH-1:0]              rx_full;
      logic [WORD_W-1:0]            rd_data;
   } pcs_port_state_t;

   // state copies and per-channel glue toward the queues
   pcs_port_state_t         s_reg;
   pcs_port_state_t         s_next;
   logic [N_CH-1:0]         rx_pin;
   logic [N_CH-1:0]         push;
   logic [N_CH-1:0]         pop;
   logic [N_CH-1:0]         f_in_ready;
   logic [N_CH-1:0]         f_out_valid;
   logic [N_CH-1:0][7:0]    f_out_data;
   logic [N_CH-1:0][7:0]    tx_code;
   logic                    rise;
   logic                    fall;
   logic [7:0]              next_bit;
   logic                    frame_start;
   logic                    rx_last;

   // linear word to mu-255 code
   function automatic logic [7:0] mu_encode(input logic [15:0] lin);
      logic        sign;
      logic [15:0] mag;
      logic [2:0]  expo;
      logic [15:0] shifted;
      logic [3:0]  sh_amt;
      sign = lin[15];
      mag  = sign ? 16'(~lin + 16'h0001) : lin;
      if (mag > MU_CLIP) begin
         mag = MU_CLIP;
      end
      mag  = mag + MU_BIAS;
      expo = 3'h0;
      for (int i = 0; i < 8; i++) begin
         if (mag[i+7]) begin
            expo = 3'(i);
         end
      end
      sh_amt  = {1'b0, expo} + 4'h3;                 // reaches 10, so wider than expo
      shifted = mag >> sh_amt;
      return ~{sign, expo, shifted[3:0]};
   endfunction : mu_encode

   // mu-255 code to linear word
   function automatic logic [15:0] mu_decode(input logic [7:0] code);
      logic [7:0]  u;
      logic [2:0]  expo;
      logic [3:0]  mant;
      logic [15:0] t;
      u    = ~code;
      expo = u[6:4];
      mant = u[3:0];
      t    = ((16'({mant, 3'b000}) + MU_BIAS) << expo) - MU_BIAS;
      return u[7] ? 16'(~t + 16'h0001) : t;
   endfunction : mu_decode

   // port address to channel decode, shared by reads and writes
   function automatic logic port_hit(input logic [2:0] addr, input int ch);
      return (ch == 0) ? (addr == PORT_CH0) : (addr == PORT_CH1);
   endfunction : port_hit

   // bit slot that carries a data bit, shared by both directions
   function automatic logic data_slot(input logic [7:0] slot);
      return (slot >= FIRST_BIT) && (slot <= LAST_BIT);
   endfunction : data_slot

   // law select decode, shared by compress and expand
   function automatic logic law_is_mu(input logic sel);
      return sel == LAW_MU;
   endfunction : law_is_mu

   // receive pins of both channels, synchronised in the state record
   assign rx_pin = {serial_rx_line_ch1, serial_rx_line_ch0};

   // queue encoded or raw samples on output instructions
   always_comb begin
      for (int c = 0; c < N_CH; c++) begin
         push[c]    = io_req.wr && port_hit(io_req.addr, c);
         tx_code[c] = law_is_mu(companding_law_select)  ? mu_encode(io_req.data)
                                                        : io_req.data[7:0];
      end
   end

   // one transmit fifo per channel
   genvar g;
   generate
      for (g = 0; g < N_CH; g++) begin : g_ch
         pcs_fifo #(
            .WIDTH (SAMPLE_BITS),
            .DEPTH (FIFO_DEPTH)
         ) u_tx_fifo (
            .clk       (clk),
            .reset     (reset),
            .in_valid  (push[g]),
            .in_ready  (f_in_ready[g]),
            .in_data   (tx_code[g]),
            .out_valid (f_out_valid[g]),
            .out_ready (pop[g]),
            .out_data  (f_out_data[g])
         );
      end
   endgenerate

   // bit clock divider, frame counter, shifters and port reads
   always_comb begin
      s_next   = s_reg;
      rise     = (s_reg.div_cnt == SCLK_LAST);
      fall     = (s_reg.div_cnt == SCLK_FALL);
      next_bit = s_reg.bit_cnt + 8'h01;
      pop      = '0;
      frame_start = rise && (s_reg.bit_cnt == FRAME_LAST);
      rx_last     = fall && (s_reg.bit_cnt == LAST_BIT);
      s_next.div_cnt = rise ? 4'h0 : s_reg.div_cnt + 4'h1;
      if (rise) begin
         s_next.sclk  = 1'b1;
         s_next.bit_cnt = next_bit;
         s_next.frame = frame_start;
      end else if (fall) begin
         s_next.sclk  = 1'b0;
      end
      for (int c = 0; c < N_CH; c++) begin
         s_next.rx_meta[c] = rx_pin[c];
         s_next.rx_sync[c] = s_reg.rx_meta[c];
         // frame start loads the next queued byte
         if (frame_start) begin
            pop[c]             = f_out_valid[c];
            s_next.tx_shift[c] = f_out_valid[c] ? f_out_data[c] : IDLE_CODE;
         end
         // transmit bit changes on rising edges, codec takes it falling
         if (rise && data_slot(next_bit)) begin
            s_next.tx_line[c]  = s_reg.tx_shift[c][7];
            s_next.tx_shift[c] = {s_reg.tx_shift[c][6:0], 1'b0};
         end
         // line parks low once bit 0 has had its slot
         if (rise && next_bit == LAST_BIT + 8'h01) begin
            s_next.tx_line[c] = 1'b0;
         end
         // a port read hands over the word and clears the flag
         if (io_req.rd && port_hit(io_req.addr, c)) begin
            s_next.rd_data    = s_reg.rx_word[c];
            s_next.rx_full[c] = 1'b0;
         end
         // receive bit sampled mid-cell, codec drives it on rising edges
         if (fall && data_slot(s_reg.bit_cnt)) begin
            s_next.rx_shift[c] = {s_reg.rx_shift[c][6:0], s_reg.rx_sync[c]};
            if (rx_last) begin
               s_next.rx_word[c] = law_is_mu(companding_law_select)
                  ? mu_decode({s_reg.rx_shift[c][6:0], s_reg.rx_sync[c]})
                  : {8'h00, s_reg.rx_shift[c][6:0], s_reg.rx_sync[c]};
               s_next.rx_full[c] = 1'b1;                                    // set wins
            end
         end
      end
      if (reset) begin
         s_next         = '0;
         s_next.bit_cnt = FRAME_LAST - 8'h01;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      s_reg <= s_next;
   end

   // outputs straight from flip-flops
   assign serial_clk         = s_reg.sclk;
   assign frame_pulse_out    = s_reg.frame;
   assign serial_tx_line_ch0 = s_reg.tx_line[0];
   assign serial_tx_line_ch1 = s_reg.tx_line[1];
   assign io_rd_data         = s_reg.rd_data;
   assign rx_sample_ready    = s_reg.rx_full;
   assign tx_space           = f_in_ready;

endmodule : pcs_serial_port

// >>> logic/pcs_pkg.sv
// shared constants and types of the codec serial port
package pcs_pkg;

   // system clock and serial timing
   localparam int          SYS_CLK_HZ      = 20_000_000;
   localparam int          SCLK_DIV        = 10;              // system clocks per bit clock
   localparam logic [3:0]  SCLK_LAST       = 4'(SCLK_DIV - 1);
   localparam logic [3:0]  SCLK_FALL       = 4'(SCLK_DIV / 2 - 1);
   localparam int          FRAME_DIV       = 256;             // bit clocks per frame
   localparam logic [7:0]  FRAME_LAST      = 8'(FRAME_DIV - 1);
   localparam int          FRAME_PERIOD_US = 125;             // nominal sample period
   localparam int          FRAME_CYCLES    = SCLK_DIV * FRAME_DIV;

   // sample framing
   localparam int          SAMPLE_BITS     = 8;
   localparam logic [7:0]  FIRST_BIT       = 8'h01;           // bit slot after the pulse
   localparam logic [7:0]  LAST_BIT        = 8'h08;
   localparam logic [7:0]  IDLE_CODE       = 8'hFF;           // encoded silence
   localparam int          WORD_W          = 16;
   localparam int          FIFO_DEPTH      = 32;
   localparam int          N_CH            = 2;

   // io port numbers of the two channels
   localparam logic [2:0]  PORT_CH0        = 3'h1;
   localparam logic [2:0]  PORT_CH1        = 3'h2;

   // mu-255 compander constants
   localparam logic [15:0] MU_BIAS         = 16'h0084;
   localparam logic [15:0] MU_CLIP         = 16'h7F7B;
   localparam logic        LAW_MU          = 1'b0;            // law select value for mu-255

   // one io instruction toward the port
   typedef struct packed {
      logic        wr;                                        // output instruction
      logic        rd;                                        // input instruction
      logic [2:0]  addr;
      logic [15:0] data;
   } pcs_io_req_t;

endpackage : pcs_pkg

// >>> logic/pcs_fifo.sv
// parameterised fifo with registered read data
`timescale 1ns/10ps
module pcs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr_ptr;
      logic [AW-1:0]               rd_ptr;
      logic [AW:0]                 count;
      logic                        in_ready;
      logic                        out_valid;
      logic [WIDTH-1:0]            out_data;
   } pcs_fifo_state_t;

   pcs_fifo_state_t s_reg;
   pcs_fifo_state_t s_next;
   logic            push;
   logic            load;

   // push, refill of the output register, pointer and count update
   always_comb begin
      s_next = s_reg;
      push   = in_valid && s_reg.in_ready;
      load   = (s_reg.count != '0) && (!s_reg.out_valid || out_ready);
      if (s_reg.out_valid && out_ready) begin
         s_next.out_valid = 1'b0;
      end
      if (load) begin
         s_next.out_data  = s_reg.mem[s_reg.rd_ptr];
         s_next.out_valid = 1'b1;
         s_next.rd_ptr    = s_reg.rd_ptr + 1'b1;
      end
      if (push) begin
         s_next.mem[s_reg.wr_ptr] = in_data;
         s_next.wr_ptr            = s_reg.wr_ptr + 1'b1;
      end
      s_next.count    = s_reg.count + (AW+1)'(push) - (AW+1)'(load);
      s_next.in_ready = (s_next.count != (AW+1)'(DEPTH));
      if (reset) begin
         s_next          = '0;
         s_next.in_ready = 1'b1;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      s_reg <= s_next;
   end

   assign in_ready  = s_reg.in_ready;
   assign out_valid = s_reg.out_valid;
   assign out_data  = s_reg.out_data;

endmodule : pcs_fifo

// >>> testbench/pcs_serial_port_checker.sv
// pin checker of the codec serial port
`timescale 1ns/10ps
module pcs_serial_port_checker
   import pcs_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire pcs_io_req_t io_req,
   input wire logic [15:0] io_rd_data,
   input wire logic [1:0]  rx_sample_ready,
   input wire logic [1:0]  tx_space,
   input wire logic        serial_clk,
   input wire logic        frame_pulse_out,
   input wire logic        serial_tx_line_ch0
);
   logic        prev_reg;
   logic        seen_reg;
   logic [11:0] gap_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // cycles since the last frame pulse rise
   always_ff @(posedge clk) begin
      prev_reg <= frame_pulse_out & ~reset;
      if (reset) begin
         seen_reg <= 1'b0;
         gap_reg  <= 12'h000;
      end else if (frame_pulse_out & ~prev_reg) begin
         seen_reg <= 1'b1;
         gap_reg  <= 12'h001;
      end else if (gap_reg != 12'hFFF) begin
         gap_reg  <= gap_reg + 12'h001;
      end
   end
   // bit clock, frame, line and read word timing
   property p_hi; $rose(serial_clk) |-> serial_clk [*5] ##1 !serial_clk; endproperty
   a_hi: assert property (p_hi) else $error("bit clock high time");
   property p_lo; $fell(serial_clk) |-> !serial_clk [*5] ##1 serial_clk; endproperty
   a_lo: assert property (p_lo) else $error("bit clock low time");
   property p_sync; $rose(frame_pulse_out) |-> $rose(serial_clk); endproperty
   a_sync: assert property (p_sync) else $error("pulse off the clock");
   property p_per; frame_pulse_out && !prev_reg && seen_reg |-> gap_reg == 12'hA00; endproperty
   a_per: assert property (p_per) else $error("frame period");
   property p_wid; $fell(frame_pulse_out) && seen_reg |-> gap_reg == 12'h00A; endproperty
   a_wid: assert property (p_wid) else $error("frame pulse width");
   property p_idle; gap_reg inside {[12'h05C:12'h9FF]} |-> !serial_tx_line_ch0; endproperty
   a_idle: assert property (p_idle) else $error("line busy outside slots");
   property p_edge; $changed(serial_tx_line_ch0) |-> $rose(serial_clk); endproperty
   a_edge: assert property (p_edge) else $error("line moved off the clock");
   property p_hold; !io_req.rd && !$past(io_req.rd) |=> $stable(io_rd_data); endproperty
   a_hold: assert property (p_hold) else $error("read word moved");
   c_frame: cover property ($rose(frame_pulse_out));
   c_full: cover property ($fell(tx_space[0]));
   c_rx: cover property ($rose(rx_sample_ready[1]));
endmodule : pcs_serial_port_checker
bind pcs_serial_port pcs_serial_port_checker u_chk (.clk(clk), .reset(reset), .io_req(io_req),
   .io_rd_data(io_rd_data), .rx_sample_ready(rx_sample_ready), .tx_space(tx_space),
   .serial_clk(serial_clk), .frame_pulse_out(frame_pulse_out),
   .serial_tx_line_ch0(serial_tx_line_ch0));

// >>> testbench/pcs_codec_model.sv
// behavioural pcm codec on one serial channel
`timescale 1ns/10ps
module pcs_codec_model (
   input  wire logic       serial_clk,
   input  wire logic       codec_tx_frame_sync,
   input  wire logic       codec_rx_frame_sync,
   input  wire logic       pcm_in,
   input  wire logic [7:0] tx_byte,
   output logic            pcm_out = 1'b0,
   output logic [7:0]      rx_byte
);
   logic [7:0] sh;
   logic       tx_go = 1'b0;
   int         tx_left = 0;
   int         rx_left = 0;
   // sync seen mid-pulse arms eight slots each way
   always @(negedge serial_clk) begin
      tx_go <= codec_tx_frame_sync;
      if (codec_rx_frame_sync) begin
         rx_left <= 8;
      end else if (rx_left > 0) begin
         rx_byte <= {rx_byte[6:0], pcm_in};
         rx_left <= rx_left - 1;
      end
   end
   // shift out msb first, toggle once released
   always @(posedge serial_clk) begin
      if (tx_go) begin
         pcm_out <= tx_byte[7];
         sh      <= {tx_byte[6:0], 1'b0};
         tx_left <= 7;
      end else if (tx_left > 0) begin
         pcm_out <= sh[7];
         sh      <= {sh[6:0], 1'b0};
         tx_left <= tx_left - 1;
      end else begin
         pcm_out <= ~pcm_out;
      end
   end
endmodule : pcs_codec_model

// >>> testbench/pcs_serial_port_tb.sv
// self-checking bench of the codec serial port
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
module pcs_serial_port_tb;
   import pcs_pkg::*;
   typedef struct packed {
      logic        law;
      logic [2:0]  addr;
      logic [15:0] wdata;
      logic [7:0]  cbyte;
      logic [7:0]  eline;
      logic [15:0] erd;
   } pcs_row_t;
   localparam pcs_row_t ROWS [7] = '{'{1'b1, 3'h1, 16'h00A5, 8'h3C, 8'hA5, 16'h003C},
      '{1'b1, 3'h1, 16'h1281, 8'h80, 8'h81, 16'h0080},
      '{1'b0, 3'h1, 16'h7FFF, 8'h80, 8'h80, 16'h7D7C},
      '{1'b0, 3'h1, 16'h0000, 8'hFF, 8'hFF, 16'h0000},
      '{1'b1, 3'h2, 16'h005A, 8'hC3, 8'h5A, 16'h00C3},
      '{1'b0, 3'h2, 16'h1000, 8'hAF, 8'hAF, 16'h0FFC},
      '{1'b0, 3'h1, 16'hF000, 8'h2F, 8'h2F, 16'hF004}};
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        law = 1'b1;
   pcs_io_req_t io_req = '0;
   logic [15:0] rd_data;
   logic [1:0]  rx_rdy;
   logic [1:0]  tx_space;
   logic        sclk;
   logic        frame;
   logic [1:0]  tx_line;
   logic [1:0]  rx_line;
   logic [7:0]  cod_tx = 8'h00;
   logic [7:0]  cod_rx [2];
   int          n_errors = 0;
   int          checked = 0;
   int          cycles = 0;
   pcs_serial_port uut (.clk(clk), .reset(reset), .companding_law_select(law), .io_req(io_req),
      .io_rd_data(rd_data), .rx_sample_ready(rx_rdy), .tx_space(tx_space), .serial_clk(sclk),
      .frame_pulse_out(frame), .serial_tx_line_ch0(tx_line[0]), .serial_rx_line_ch0(rx_line[0]),
      .serial_tx_line_ch1(tx_line[1]), .serial_rx_line_ch1(rx_line[1]));
   for (genvar c = 0; c < 2; c++) begin : g_codec
      pcs_codec_model u_codec (.serial_clk(sclk), .codec_tx_frame_sync(frame),
         .codec_rx_frame_sync(frame), .pcm_in(tx_line[c]), .tx_byte(cod_tx),
         .pcm_out(rx_line[c]), .rx_byte(cod_rx[c]));
   end
   // clock and hang limit
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         n_errors++;
         summarize();
      end
   end
   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick
   task automatic io_op(input logic wr, input logic [2:0] addr, input logic [15:0] data);
      io_req = '{wr, ~wr, addr, data};
      tick();
   endtask : io_op
   task automatic wait_frame();
      io_req = '0;
      for (int n = 0; n < 3000 && frame !== 1'b0; n++) tick();
      for (int n = 0; n < 3000 && frame !== 1'b1; n++) tick();
      `CHK("frame pulse", 1'b1, frame)
   endtask : wait_frame
   task automatic wait_rdy(input int ch);
      io_req = '0;
      for (int n = 0; n < 300 && rx_rdy[ch] !== 1'b1; n++) tick();
      `CHK("sample ready", 1'b1, rx_rdy[ch])
   endtask : wait_rdy
   task automatic do_reset();
      reset = 1'b1;
      io_req = '0;
      repeat (3) tick();
      `CHK("reset outputs", 24'h00_0003, {sclk, frame, tx_line, rd_data, rx_rdy, tx_space})
      reset = 1'b0;
   endtask : do_reset
   task automatic summarize();
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize
   // table rows, then idle, full queue and mid-run reset
   initial begin
      do_reset();
      foreach (ROWS[i]) begin
         law = ROWS[i].law;
         cod_tx = ROWS[i].cbyte;
         wait_frame();
         io_op(1'b1, ROWS[i].addr, ROWS[i].wdata);
         wait_frame();
         io_op(1'b0, ROWS[i].addr, 16'h0000);
         wait_rdy(ROWS[i].addr == PORT_CH1);
         `CHK("codec byte", ROWS[i].eline, cod_rx[ROWS[i].addr == PORT_CH1])
         io_op(1'b0, ROWS[i].addr, 16'h0000);
         io_req = '0;
         tick();
         `CHK("read word", ROWS[i].erd, rd_data)
         `CHK("ready cleared", 1'b0, rx_rdy[ROWS[i].addr == PORT_CH1])
      end
      law = 1'b1;
      wait_frame();
      io_op(1'b1, 3'h3, 16'h0011);
      wait_frame();
      io_op(1'b0, PORT_CH0, 16'h0000);
      wait_rdy(0);
      `CHK("idle byte", IDLE_CODE, cod_rx[0])
      wait_frame();
      for (int i = 0; i <= FIFO_DEPTH; i++) io_op(1'b1, PORT_CH0, 16'(i + 1));
      io_req = '0;
      tick();
      `CHK("space when full", 2'b10, tx_space)
      wait_frame();
      io_op(1'b0, PORT_CH0, 16'h0000);
      wait_rdy(0);
      `CHK("first queued", 8'h01, cod_rx[0])
      `CHK("space after pop", 2'b11, tx_space)
      do_reset();
      wait_frame();
      wait_rdy(0);
      `CHK("byte after reset", IDLE_CODE, cod_rx[0])
      summarize();
   end
endmodule : pcs_serial_port_tb
